// file: verilog/phy_status_irq_regs.sv
// live phy status word, interrupt mask word and the event latches behind
// the management interrupt pin.
// assumes one clock, a register access port from the management serial
// engine (one-cycle rd/wr strobes) and phy core status levels and pulses.
`timescale 1ns/10ps

// Contract
// - bit 17.14 high in 100 mbit mode
// - bit 17.13 follows transmit activity
// - bit 17.12 follows receive activity
// - bit 17.11 shows current collision
// - bit 17.10 shows link up
// - bit 17.9 shows full duplex
// - bit 17.8 shows auto-negotiation mode
// - bit 17.7 mirrors negotiation complete
// - bit 17.5 shows reversed receive polarity
// - bit 17.4 shows pause capability
// - bit 17.3 set on any fault
// - error cleared by reading source registers
// - negotiation-done interrupt gated by mask bit 7
// - speed-change interrupt gated by mask bit 6
// - duplex-change interrupt gated by mask bit 5
// - link-change interrupt gated by mask bit 4
// - global enable bit 1 gates interrupts
// - test bit 0 forces interrupt
// - change events latched, cleared on event read
// - bit 19.2 shows interrupt pending
module phy_status_irq_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // phy core status
  input wire phy_mgmt_pkg::phy_live_t live,
  input wire phy_mgmt_pkg::phy_fault_t fault,
  // management register access
  input wire phy_mgmt_pkg::mgmt_req_t req,
  output phy_mgmt_pkg::mgmt_rsp_t rsp,
  // management interrupt, active low
  output logic mgmt_irq_n
);
  import phy_mgmt_pkg::*;

  typedef struct packed {
    logic autoneg_done_mask;
    logic speed_change_mask;
    logic duplex_change_mask;
    logic link_change_mask;
    logic irq_global_enable;
    logic irq_test_force;
    phy_live_t live_prev;
    logic [3:0] event_latch;
    logic [2:0] fault_latch;
    logic irq_pending;
    logic [15:0] rdata;
    logic rvalid;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [3:0] event_now;
  logic [3:0] event_mask;
  logic [15:0] live_word_now;
  logic [15:0] mask_word_now;
  logic [15:0] event_word_now;
  logic rd_live;
  logic rd_mask;
  logic rd_event;
  logic rd_basic;
  logic rd_anx;
  logic wr_mask;

  // live status word; reserved bits 15, 6, 2..0 stay zero
  function automatic logic [15:0] live_word(input phy_live_t s,
                                            input logic err);
    logic [15:0] w;
    w = LIVE_STATE_RESET;
    w[LS_SPEED_100] = s.speed_100;
    w[LS_TX_ACTIVE] = s.tx_active;
    w[LS_RX_ACTIVE] = s.rx_active;
    w[LS_COLLISION] = s.collision;
    w[LS_LINK_UP] = s.link_up;
    w[LS_FULL_DUPLEX] = s.full_duplex;
    w[LS_AUTONEG_ON] = s.autoneg_on;
    w[LS_AUTONEG_DONE] = s.autoneg_done;
    // polarity flag, meaningless at 100 mbit
    w[LS_POLARITY_REV] = s.polarity_rev;
    w[LS_PAUSE] = s.pause_capable;
    w[LS_ERROR] = err;
    return w;
  endfunction

  // register decode, used for both read and write strobes
  function automatic logic hit(input mgmt_req_t r, input logic [4:0] a);
    return r.addr == a;
  endfunction

  // strobes per register
  assign rd_live = req.rd && hit(req, ADDR_LIVE_STATE);
  assign rd_mask = req.rd && hit(req, ADDR_IRQ_MASK);
  assign rd_event = req.rd && hit(req, ADDR_EVENT);
  assign rd_basic = req.rd && hit(req, ADDR_BASIC_STATUS);
  assign rd_anx = req.rd && hit(req, ADDR_AN_EXPANSION);
  assign wr_mask = req.wr && hit(req, ADDR_IRQ_MASK);

  // change detection against last sampled status
  // negotiation done counts only on its rising edge
  assign event_now[EVI_AUTONEG] = live.autoneg_done &&
                                  !state_reg.live_prev.autoneg_done;
  assign event_now[EVI_SPEED] = live.speed_100 ^
                                state_reg.live_prev.speed_100;
  assign event_now[EVI_DUPLEX] = live.full_duplex ^
                                 state_reg.live_prev.full_duplex;
  assign event_now[EVI_LINK] = live.link_up ^ state_reg.live_prev.link_up;

  // mask vector in event order
  assign event_mask = {state_reg.autoneg_done_mask,
                       state_reg.speed_change_mask,
                       state_reg.duplex_change_mask,
                       state_reg.link_change_mask};

  // read views of the three words
  assign live_word_now = live_word(live, |state_reg.fault_latch);

  // reserved mask bits read zero regardless of what was written
  always_comb begin
    mask_word_now = IRQ_MASK_RESET;
    mask_word_now[IM_AUTONEG_DONE] = state_reg.autoneg_done_mask;
    mask_word_now[IM_SPEED] = state_reg.speed_change_mask;
    mask_word_now[IM_DUPLEX] = state_reg.duplex_change_mask;
    mask_word_now[IM_LINK] = state_reg.link_change_mask;
    mask_word_now[IM_GLOBAL_EN] = state_reg.irq_global_enable;
    mask_word_now[IM_TEST_FORCE] = state_reg.irq_test_force;
  end

  // event word; bit 7 reports live negotiation status
  always_comb begin
    event_word_now = LIVE_STATE_RESET;
    event_word_now[EV_AUTONEG_DONE] = live.autoneg_done;
    event_word_now[EV_SPEED] = state_reg.event_latch[EVI_SPEED];
    event_word_now[EV_DUPLEX] = state_reg.event_latch[EVI_DUPLEX];
    event_word_now[EV_LINK] = state_reg.event_latch[EVI_LINK];
    event_word_now[EV_IRQ_PENDING] = state_reg.irq_pending;
  end

  // next state
  always_comb begin
    state_next = state_reg;
    state_next.live_prev = live;

    // reserved bits of the write are dropped
    if (wr_mask) begin
      state_next.autoneg_done_mask = req.wdata[IM_AUTONEG_DONE];
      state_next.speed_change_mask = req.wdata[IM_SPEED];
      state_next.duplex_change_mask = req.wdata[IM_DUPLEX];
      state_next.link_change_mask = req.wdata[IM_LINK];
      state_next.irq_global_enable = req.wdata[IM_GLOBAL_EN];
      state_next.irq_test_force = req.wdata[IM_TEST_FORCE];
    end

    // clear on event read, a new edge wins over the clear
    if (rd_event) begin
      state_next.event_latch = event_now;
    end else begin
      state_next.event_latch = state_reg.event_latch | event_now;
    end

    // remote fault and jabber live in basic status
    // parallel detect fault in negotiation expansion
    state_next.fault_latch[2] = (state_reg.fault_latch[2] && !rd_basic) ||
                                fault.remote_fault;
    state_next.fault_latch[1] = (state_reg.fault_latch[1] && !rd_basic) ||
                                fault.jabber;
    // only a new parallel detect fault sets latch bit 0
    state_next.fault_latch[0] = (state_reg.fault_latch[0] && !rd_anx) ||
                                fault.par_detect_fault;

    // test bit forces regardless of enable
    state_next.irq_pending = state_reg.irq_test_force ||
                             (state_reg.irq_global_enable &&
                              |(state_next.event_latch & event_mask));

    // one-cycle read answer; unmapped addresses read zero
    state_next.rvalid = req.rd;
    if (rd_live) begin
      state_next.rdata = live_word_now;
    end else if (rd_mask) begin
      state_next.rdata = mask_word_now;
    end else if (rd_event) begin
      state_next.rdata = event_word_now;
    end else if (req.rd) begin
      state_next.rdata = RDATA_RESET;
    end
  end

  // state register
  // every defined bit comes out of reset as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign rsp.valid = state_reg.rvalid;
  assign rsp.data = state_reg.rdata;
  assign mgmt_irq_n = !state_reg.irq_pending;

endmodule

// file: verilog/phy_mgmt_pkg.sv
// constants and carrier types for the phy status and interrupt mask bank
// assumes a 5-bit management register address space, 16-bit words
package phy_mgmt_pkg;

  // management register addresses
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_AN_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_LIVE_STATE = 5'h11;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h12;
  localparam logic [4:0] ADDR_EVENT = 5'h13;

  // live_phy_state field positions
  localparam int LS_SPEED_100 = 14;
  localparam int LS_TX_ACTIVE = 13;
  localparam int LS_RX_ACTIVE = 12;
  localparam int LS_COLLISION = 11;
  localparam int LS_LINK_UP = 10;
  localparam int LS_FULL_DUPLEX = 9;
  localparam int LS_AUTONEG_ON = 8;
  localparam int LS_AUTONEG_DONE = 7;
  localparam int LS_POLARITY_REV = 5;
  localparam int LS_PAUSE = 4;
  localparam int LS_ERROR = 3;

  // event_irq_mask field positions
  localparam int IM_AUTONEG_DONE = 7;
  localparam int IM_SPEED = 6;
  localparam int IM_DUPLEX = 5;
  localparam int IM_LINK = 4;
  localparam int IM_GLOBAL_EN = 1;
  localparam int IM_TEST_FORCE = 0;

  // event register field positions
  localparam int EV_AUTONEG_DONE = 7;
  localparam int EV_SPEED = 6;
  localparam int EV_DUPLEX = 5;
  localparam int EV_LINK = 4;
  localparam int EV_IRQ_PENDING = 2;

  // event vector order inside the block: {autoneg, speed, duplex, link}
  localparam int EVI_AUTONEG = 3;
  localparam int EVI_SPEED = 2;
  localparam int EVI_DUPLEX = 1;
  localparam int EVI_LINK = 0;

  // reset values
  localparam logic [15:0] LIVE_STATE_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // live status from the phy core, levels
  typedef struct packed {
    logic speed_100;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic link_up;
    logic full_duplex;
    logic autoneg_on;
    logic autoneg_done;
    logic polarity_rev;
    logic pause_capable;
  } phy_live_t;

  // fault events from the phy core, one-cycle pulses
  typedef struct packed {
    logic remote_fault;
    logic jabber;
    logic par_detect_fault;
  } phy_fault_t;

  // management register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // management read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } mgmt_rsp_t;

endpackage

// file: test/phy_status_irq_monitor.sv
// port checker for the status and interrupt mask bank
// assumes one clock and an async active-high reset
`timescale 1ns/10ps
module phy_status_irq_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire phy_mgmt_pkg::phy_live_t live,
  input wire phy_mgmt_pkg::phy_fault_t fault,
  input wire phy_mgmt_pkg::mgmt_req_t req,
  input wire phy_mgmt_pkg::mgmt_rsp_t rsp,
  input wire logic mgmt_irq_n
);
  import phy_mgmt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // live word answers one cycle after the read
  property p_live;
    req.rd && req.addr == ADDR_LIVE_STATE |=> rsp.valid && !rsp.data[15]
      && rsp.data[14:7] == $past(live[9:2]) && !rsp.data[6]
      && rsp.data[5:4] == $past(live[1:0]) && rsp.data[2:0] == 3'h0;
  endproperty
  a_live: assert property (p_live)
    else $error("live word wrong");
  property p_err_set;
    fault != 3'h0 ##1 req.rd && req.addr == ADDR_LIVE_STATE
      |=> rsp.data[LS_ERROR];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error bit not set");
  property p_err_clr;
    (req.rd && req.addr == ADDR_BASIC_STATUS && fault == 3'h0)
      ##1 (req.rd && req.addr == ADDR_AN_EXPANSION && fault == 3'h0)
      ##1 (req.rd && req.addr == ADDR_LIVE_STATE) |=> !rsp.data[LS_ERROR];
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error bit not cleared");
  property p_mask_rsvd;
    rsp.valid && $past(req.addr) == ADDR_IRQ_MASK
      |-> rsp.data[15:8] == 8'h00 && rsp.data[3:2] == 2'h0;
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd)
    else $error("reserved mask bits read back");
  property p_gate;
    req.wr && req.addr == ADDR_IRQ_MASK && req.wdata[1:0] == 2'h0
      |=> ##1 mgmt_irq_n;
  endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt with enable off");
  property p_force;
    req.wr && req.addr == ADDR_IRQ_MASK && req.wdata[0] |=> ##1 !mgmt_irq_n;
  endproperty
  a_force: assert property (p_force)
    else $error("test force ignored");
  property p_pend;
    rsp.valid && $past(req.addr) == ADDR_EVENT
      |-> rsp.data[EV_IRQ_PENDING] == !$past(mgmt_irq_n);
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending bit disagrees with pin");
  // a second read with steady status must find no change left
  property p_ev_clr;
    (!$past(rst) && req.rd && req.addr == ADDR_EVENT && $stable(live))
      ##1 (req.rd && req.addr == ADDR_EVENT && $stable(live))
      |=> rsp.data[6:4] == 3'h0;
  endproperty
  a_ev_clr: assert property (p_ev_clr)
    else $error("change flags not cleared");
endmodule
bind phy_status_irq_regs phy_status_irq_monitor mon_i (.clock(clock),
  .rst(rst), .live(live), .fault(fault), .req(req), .rsp(rsp),
  .mgmt_irq_n(mgmt_irq_n));

// file: test/mgmt_station.sv
// management station model issuing one-cycle register strobes
// assumes tasks are entered just after a rising edge
`timescale 1ns/10ps
module mgmt_station (
  // clock
  input wire logic clock,
  // register port
  input wire phy_mgmt_pkg::mgmt_rsp_t rsp,
  output phy_mgmt_pkg::mgmt_req_t req,
  // last answered read word
  output logic [15:0] last
);
  import phy_mgmt_pkg::*;
  initial req = '0;
  // capture mid-cycle, away from the edge that launches the answer
  always @(negedge clock) begin
    if (rsp.valid) last = rsp.data;
  end
  // unused write data toggles so nothing leans on stale values
  task automatic rd(input logic [4:0] a);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~req.wdata};
    last = 16'hxxxx;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d & 16'h00f3};
    @(posedge clock);
    #1;
  endtask
  task automatic idle;
    req = '{rd: 1'b0, wr: 1'b0, addr: 5'h00, wdata: ~req.wdata};
    @(posedge clock);
    #1;
  endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the status and interrupt mask bank
// assumes the station model drives the register port
`timescale 1ns/10ps
module testbench;
  import phy_mgmt_pkg::*;
  logic clock, rst, mgmt_irq_n;
  phy_live_t live;
  phy_fault_t fault;
  mgmt_req_t req;
  mgmt_rsp_t rsp;
  logic [15:0] got, mk;
  int mismatches, n_compared, i, k, m;
  int lb[4] = '{5, 4, 9, 2};
  phy_status_irq_regs phy_status_irq_regs_i (.clock(clock), .rst(rst),
    .live(live), .fault(fault), .req(req), .rsp(rsp),
    .mgmt_irq_n(mgmt_irq_n));
  mgmt_station mgmt_station_i (.clock(clock), .rsp(rsp), .req(req),
    .last(got));
  // 25 mhz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [15:0] live_word(phy_live_t l, logic e);
    return {1'b0, l[9:2], 1'b0, l[1:0], e, 3'h0};
  endfunction
  function automatic logic [15:0] ev_word(int k, logic p);
    return (k == 3 ? 16'h0080 : 16'h0010 << k) | {13'h0, p, 2'h0};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    mgmt_station_i.rd(a);
    mgmt_station_i.idle();
    mgmt_station_i.idle();
    chk("rdata", e, got);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    live = '0;
    fault = '0;
    rst = 1'b1;
    void'($urandom(34382));
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    chk("irq_n", 16'h0001, {15'h0, mgmt_irq_n});
    rdc(ADDR_IRQ_MASK, IRQ_MASK_RESET);
    rdc(5'h1f, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 40; i++) begin
      live = 10'($urandom);
      rdc(ADDR_LIVE_STATE, live_word(live, 1'b0));
    end
    $display("test live done");
    live = '0;
    for (i = 0; i < 3; i++) begin
      fault = 3'(1 << i);
      mgmt_station_i.idle();
      fault = '0;
      rdc(ADDR_LIVE_STATE, 16'h0008);
      mgmt_station_i.rd(ADDR_BASIC_STATUS);
      mgmt_station_i.rd(ADDR_AN_EXPANSION);
      rdc(ADDR_LIVE_STATE, 16'h0000);
    end
    $display("test fault done");
    for (k = 0; k < 4; k++) begin
      for (m = 0; m < 3; m++) begin
        mk = 16'(1 << (4 + (m == 2 ? (k + 1) % 4 : k)));
        mk = mk | (m == 1 ? 16'h0000 : 16'h0002);
        live = '0;
        mgmt_station_i.wr(ADDR_IRQ_MASK, mk);
        mgmt_station_i.rd(ADDR_EVENT);
        mgmt_station_i.rd(ADDR_EVENT);
        mgmt_station_i.idle();
        chk("irq_n", 16'h0001, {15'h0, mgmt_irq_n});
        live[lb[k]] = 1'b1;
        mgmt_station_i.idle();
        mgmt_station_i.idle();
        chk("irq_n", {15'h0, m != 0}, {15'h0, mgmt_irq_n});
        rdc(ADDR_EVENT, ev_word(k, m == 0));
      end
    end
    $display("test irq done");
    mgmt_station_i.wr(ADDR_IRQ_MASK, 16'h0001);
    mgmt_station_i.wr(ADDR_LIVE_STATE, 16'h00f2);
    mgmt_station_i.idle();
    chk("irq_n", 16'h0000, {15'h0, mgmt_irq_n});
    rdc(ADDR_IRQ_MASK, 16'h0001);
    mgmt_station_i.wr(ADDR_IRQ_MASK, 16'h0000);
    mgmt_station_i.idle();
    mgmt_station_i.idle();
    chk("irq_n", 16'h0001, {15'h0, mgmt_irq_n});
    $display("test force done");
    test_done();
  end
  // watchdog, about thirty-six times the expected run
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule
